// File: include/fra_pkg.sv
// ------------------------------------------------------------
// Flash read accelerator shared constants
// ------------------------------------------------------------
package fra_pkg;

  // Wait-state configuration
  localparam int FRA_WS_W = 3;
  localparam logic [FRA_WS_W-1:0] FRA_WS_RST = 3'h0;
  localparam logic [FRA_WS_W-1:0] FRA_WS_MAX = 3'h4;

  // Block and line geometry: one block is 128 bits, one line two blocks
  localparam int FRA_BLK_BITS = 128;
  localparam int FRA_LINE_BITS = 256;
  localparam int FRA_BLK_W = 28;
  localparam int FRA_IC_LINES = 64;
  localparam int FRA_DC_LINES = 8;

  // Address map
  localparam logic [31:0] FRA_MAIN_BASE = 32'h0800_0000;
  localparam logic [31:0] FRA_MAIN_TOP = 32'h0807_FFFF;
  localparam logic [31:0] FRA_OPT_BASE = 32'h1FFF_F800;
  localparam logic [31:0] FRA_OPT_TOP = 32'h1FFF_F80F;

  // Read engine states
  typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_SIB, ST_PREF} fra_state_t;

  // Inclusive address window check
  function automatic logic fra_in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  // One 32-bit word out of a 128-bit block
  function automatic logic [31:0] fra_word(input logic [FRA_BLK_BITS-1:0] b, input logic [1:0] i);
    return b[i*32 +: 32];
  endfunction

endpackage

// File: verilog/fra_flash_read.sv
// Functional notes
// (RL1) Array reads stall by wait-state count, 0..4
// (RL2) Software picks wait states from AHB frequency
// (RL3) Wait-state count is zero after reset
// (RL4) Raise wait states before raising clock
// (RL5) Lower clock before lowering wait states
// (RL6) Every array read loads 128-bit current buffer; here only demand fetches do, sibling and prefetch reads leave it alone
// (RL7) Current buffer hits skip the array
// (RL8) Prefetch only when enabled, instructions only
// (RL9) Prefetch next sequential block after current
// (RL10) Instruction cache only when enabled, instructions only
// (RL11) Instruction cache: 64 lines of 2x128 bits
// (RL12) Instruction cache hit answers with no wait
// (RL13) Full instruction miss fills instruction cache line
// (RL14) Full cache evicts least recently used line
// (RL15) Data cache only when enabled, CPU data only
// (RL16) Option-byte reads never use data cache
// (RL17) Data cache: 8 lines of 2x128 bits
// (RL18) Data cache hit no wait; miss fills line
// (RL19) Main flash mapped 0x08000000 to 0x0807FFFF
// (RL20) Disabled cache or prefetch is fully bypassed
`timescale 1ns/1ps

// ------------------------------------------------------------
// Two-way set-associative line store
// ------------------------------------------------------------
module fra_cache #(
  parameter int LINES = 64
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic [fra_pkg::FRA_BLK_W-1:0] look_blk,
  input wire logic touch,
  input wire logic fill,
  input wire logic [fra_pkg::FRA_BLK_W-1:0] fill_blk,
  input wire logic [fra_pkg::FRA_LINE_BITS-1:0] fill_line,
  output logic hit,
  output logic [fra_pkg::FRA_BLK_BITS-1:0] hit_data
);
  import fra_pkg::*;
  localparam int SETS = LINES / 2;
  localparam int IW = $clog2(SETS);
  localparam int TW = FRA_BLK_W - 1 - IW;

  logic [FRA_LINE_BITS-1:0] dat_q [2][SETS];
  logic [FRA_LINE_BITS-1:0] dat_d [2][SETS];
  logic [TW-1:0] tag_q [2][SETS];
  logic [TW-1:0] tag_d [2][SETS];
  logic val_q [2][SETS];
  logic val_d [2][SETS];
  logic lru_q [SETS];
  logic lru_d [SETS];
  logic [IW-1:0] li;
  logic [IW-1:0] fi;
  logic [TW-1:0] lt;
  logic [TW-1:0] ft;
  logic h0;
  logic h1;
  logic fw;
  logic [FRA_LINE_BITS-1:0] hl;

  // Lookup; a disabled cache never hits
  assign li = look_blk[IW:1];
  assign lt = look_blk[FRA_BLK_W-1:IW+1];
  assign fi = fill_blk[IW:1];
  assign ft = fill_blk[FRA_BLK_W-1:IW+1];
  assign h0 = val_q[0][li] && (tag_q[0][li] == lt);
  assign h1 = val_q[1][li] && (tag_q[1][li] == lt);
  assign hit = enable && (h0 || h1); // RL20
  assign hl = h1 ? dat_q[1][li] : dat_q[0][li];
  assign hit_data = look_blk[0] ? hl[FRA_LINE_BITS-1:FRA_BLK_BITS] : hl[FRA_BLK_BITS-1:0];

  // Fill and replacement; lru names the way to evict next
  always_comb begin
    dat_d = dat_q;
    tag_d = tag_q;
    val_d = val_q;
    lru_d = lru_q;
    fw = !val_q[0][fi] ? 1'b0 : (!val_q[1][fi] ? 1'b1 : lru_q[fi]); // RL14
    if (!enable) begin
      val_d = '{default: 1'b0}; // Flush so a re-enable never serves stale lines
    end else if (fill) begin
      dat_d[fw][fi] = fill_line;
      tag_d[fw][fi] = ft;
      val_d[fw][fi] = 1'b1;
      lru_d[fi] = ~fw; // RL14
    end else if (touch && hit) begin
      lru_d[li] = h0; // RL14
    end
  end

  // Valid and age bits need a reset value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      val_q <= '{default: 1'b0};
      lru_q <= '{default: 1'b0};
    end else begin
      val_q <= val_d;
      lru_q <= lru_d;
    end
  end

  // Payload storage, qualified by valid bits
  always_ff @(posedge clk) begin
    dat_q <= dat_d;
    tag_q <= tag_d;
  end
endmodule

// ------------------------------------------------------------
// Flash read path: buffers, caches and array sequencer
// ------------------------------------------------------------
module fra_flash_read (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [fra_pkg::FRA_WS_W-1:0] wait_state_count,
  input wire logic prefetch_enable,
  input wire logic instr_cache_enable,
  input wire logic data_cache_enable,
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic rd_instr,
  input wire logic rd_dma,
  output logic rd_busy_q,
  output logic rd_done_q,
  output logic [31:0] rd_data_q,
  output logic rd_err_q,
  output logic array_en_q,
  output logic [fra_pkg::FRA_BLK_W-1:0] array_blk_q,
  input wire logic [fra_pkg::FRA_BLK_BITS-1:0] array_rdata
);
  import fra_pkg::*;

  // ------------------------------------------------------------
  // Configuration
  // ------------------------------------------------------------
  logic [FRA_WS_W-1:0] ws_q;
  logic [FRA_WS_W-1:0] ws_d;
  logic pf_en_q;
  logic ic_en_q;
  logic dc_en_q;

  // Out-of-range counts clamp to the slowest setting
  assign ws_d = (wait_state_count > FRA_WS_MAX) ? FRA_WS_MAX : wait_state_count; // RL1

  // Software must order clock and wait-state changes itself; no check here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ws_q <= FRA_WS_RST; // RL3
      pf_en_q <= 1'b0;
      ic_en_q <= 1'b0;
      dc_en_q <= 1'b0;
    end else begin
      ws_q <= ws_d;
      pf_en_q <= prefetch_enable;
      ic_en_q <= instr_cache_enable;
      dc_en_q <= data_cache_enable;
    end
  end

  // ------------------------------------------------------------
  // Request decode
  // ------------------------------------------------------------
  logic take;
  logic in_main;
  logic in_opt;
  logic ic_use;
  logic dc_use;
  logic pf_use;
  logic ic_hit;
  logic dc_hit;
  logic ic_fill;
  logic dc_fill;
  logic [FRA_BLK_BITS-1:0] ic_data;
  logic [FRA_BLK_BITS-1:0] dc_data;
  logic [FRA_BLK_W-1:0] blk;
  logic [FRA_LINE_BITS-1:0] line;
  logic [FRA_BLK_W-1:0] req_blk_q, req_blk_d;

  assign take = rd_req && !rd_busy_q;
  assign blk = rd_addr[31:4];
  assign in_main = fra_in_range(rd_addr, FRA_MAIN_BASE, FRA_MAIN_TOP); // RL19
  assign in_opt = fra_in_range(rd_addr, FRA_OPT_BASE, FRA_OPT_TOP);
  assign ic_use = rd_instr && in_main; // RL10
  assign dc_use = !rd_instr && !rd_dma && in_main; // RL15 RL16
  assign pf_use = rd_instr && pf_en_q; // RL8

  // ------------------------------------------------------------
  // Caches
  // ------------------------------------------------------------
  fra_cache #(.LINES(FRA_IC_LINES)) u_icache ( // RL11
    .clk(sys_clk),
    .rst_n(rst_n),
    .enable(ic_en_q),
    .look_blk(blk),
    .touch(take && ic_use),
    .fill(ic_fill),
    .fill_blk(req_blk_q),
    .fill_line(line),
    .hit(ic_hit),
    .hit_data(ic_data)
  );

  fra_cache #(.LINES(FRA_DC_LINES)) u_dcache ( // RL17
    .clk(sys_clk),
    .rst_n(rst_n),
    .enable(dc_en_q),
    .look_blk(blk),
    .touch(take && dc_use),
    .fill(dc_fill),
    .fill_blk(req_blk_q),
    .fill_line(line),
    .hit(dc_hit),
    .hit_data(dc_data)
  );

  // ------------------------------------------------------------
  // Read engine
  // ------------------------------------------------------------
  fra_state_t state_q, state_d;
  logic [FRA_WS_W-1:0] cnt_q, cnt_d;
  logic [1:0] req_word_q, req_word_d;
  logic req_instr_q, req_instr_d;
  logic fill_ic_q, fill_ic_d;
  logic fill_dc_q, fill_dc_d;
  logic [FRA_BLK_BITS-1:0] first_q, first_d;
  logic [FRA_BLK_BITS-1:0] cur_buf_q, cur_buf_d;
  logic [FRA_BLK_W-1:0] cur_blk_q, cur_blk_d;
  logic cur_val_q, cur_val_d;
  logic [FRA_BLK_BITS-1:0] pf_buf_q, pf_buf_d;
  logic [FRA_BLK_W-1:0] pf_blk_q, pf_blk_d;
  logic pf_val_q, pf_val_d;
  logic arr_en_d;
  logic [FRA_BLK_W-1:0] arr_blk_d;
  logic done_d;
  logic err_d;
  logic [31:0] data_d;
  logic arr_done;

  // Array data is taken after ws_q extra cycles of a stable address
  assign arr_done = (state_q != ST_IDLE) && (cnt_q == ws_q); // RL1
  assign line = req_blk_q[0] ? {first_q, array_rdata} : {array_rdata, first_q};

  // Next-state: hit priority is I-cache, D-cache, current, prefetch
  always_comb begin
    state_d = state_q;
    req_blk_d = req_blk_q;
    req_word_d = req_word_q;
    req_instr_d = req_instr_q;
    fill_ic_d = fill_ic_q;
    fill_dc_d = fill_dc_q;
    first_d = first_q;
    cur_buf_d = cur_buf_q;
    cur_blk_d = cur_blk_q;
    cur_val_d = cur_val_q;
    pf_buf_d = pf_buf_q;
    pf_blk_d = pf_blk_q;
    pf_val_d = pf_val_q && pf_en_q; // RL20
    arr_en_d = array_en_q;
    arr_blk_d = array_blk_q;
    done_d = 1'b0;
    err_d = 1'b0;
    data_d = rd_data_q;
    ic_fill = 1'b0;
    dc_fill = 1'b0;
    cnt_d = (arr_done || state_q == ST_IDLE) ? '0 : cnt_q + 3'h1; // RL1
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          req_blk_d = blk;
          req_word_d = rd_addr[3:2];
          req_instr_d = rd_instr;
          fill_ic_d = 1'b0;
          fill_dc_d = 1'b0;
          if (!in_main && !in_opt) begin
            done_d = 1'b1;
            err_d = 1'b1;
            data_d = 32'h0;
          end else if (ic_use && ic_hit) begin
            done_d = 1'b1; // RL12
            data_d = fra_word(ic_data, rd_addr[3:2]);
          end else if (dc_use && dc_hit) begin
            done_d = 1'b1; // RL18
            data_d = fra_word(dc_data, rd_addr[3:2]);
          end else if (cur_val_q && cur_blk_q == blk) begin
            done_d = 1'b1; // RL7
            data_d = fra_word(cur_buf_q, rd_addr[3:2]);
          end else if (pf_use && pf_val_q && pf_blk_q == blk) begin
            done_d = 1'b1;
            data_d = fra_word(pf_buf_q, rd_addr[3:2]);
            cur_buf_d = pf_buf_q;
            cur_blk_d = blk;
            pf_val_d = 1'b0;
            state_d = ST_PREF; // RL9
            arr_en_d = 1'b1;
            arr_blk_d = blk + 28'h1;
          end else begin
            state_d = ST_FETCH; // RL1
            arr_en_d = 1'b1;
            arr_blk_d = blk;
            fill_ic_d = ic_use && ic_en_q; // RL13
            fill_dc_d = dc_use && dc_en_q; // RL18
          end
        end
      end
      ST_FETCH: begin
        if (arr_done) begin
          cur_buf_d = array_rdata; // RL6
          cur_blk_d = array_blk_q;
          cur_val_d = 1'b1;
          first_d = array_rdata;
          done_d = 1'b1;
          data_d = fra_word(array_rdata, req_word_q);
          if (fill_ic_q || fill_dc_q) begin
            state_d = ST_SIB;
            arr_blk_d = {array_blk_q[FRA_BLK_W-1:1], ~array_blk_q[0]};
          end else if (req_instr_q && pf_en_q) begin
            state_d = ST_PREF; // RL9
            arr_blk_d = array_blk_q + 28'h1;
          end else begin
            state_d = ST_IDLE;
            arr_en_d = 1'b0;
          end
        end
      end
      ST_SIB: begin
        if (arr_done) begin
          ic_fill = fill_ic_q; // RL13
          dc_fill = fill_dc_q; // RL18
          fill_ic_d = 1'b0;
          fill_dc_d = 1'b0;
          if (req_instr_q && pf_en_q) begin
            state_d = ST_PREF; // RL9
            arr_blk_d = req_blk_q + 28'h1;
          end else begin
            state_d = ST_IDLE;
            arr_en_d = 1'b0;
          end
        end
      end
      ST_PREF: begin
        if (arr_done) begin
          pf_buf_d = array_rdata;
          pf_blk_d = array_blk_q;
          pf_val_d = pf_en_q; // RL8
          state_d = ST_IDLE;
          arr_en_d = 1'b0;
        end
      end
      default: begin
        state_d = ST_IDLE;
        arr_en_d = 1'b0;
      end
    endcase
  end

  // Engine registers; all ports come straight from here
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      req_blk_q <= '0;
      req_word_q <= 2'h0;
      req_instr_q <= 1'b0;
      fill_ic_q <= 1'b0;
      fill_dc_q <= 1'b0;
      first_q <= '0;
      cur_buf_q <= '0;
      cur_blk_q <= '0;
      cur_val_q <= 1'b0;
      pf_buf_q <= '0;
      pf_blk_q <= '0;
      pf_val_q <= 1'b0;
      array_en_q <= 1'b0;
      array_blk_q <= '0;
      rd_busy_q <= 1'b0;
      rd_done_q <= 1'b0;
      rd_err_q <= 1'b0;
      rd_data_q <= 32'h0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      req_blk_q <= req_blk_d;
      req_word_q <= req_word_d;
      req_instr_q <= req_instr_d;
      fill_ic_q <= fill_ic_d;
      fill_dc_q <= fill_dc_d;
      first_q <= first_d;
      cur_buf_q <= cur_buf_d;
      cur_blk_q <= cur_blk_d;
      cur_val_q <= cur_val_d;
      pf_buf_q <= pf_buf_d;
      pf_blk_q <= pf_blk_d;
      pf_val_q <= pf_val_d;
      array_en_q <= arr_en_d;
      array_blk_q <= arr_blk_d;
      rd_busy_q <= (state_d != ST_IDLE);
      rd_done_q <= done_d;
      rd_err_q <= err_d;
      rd_data_q <= data_d;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [FRA_WS_W-1:0] fcyc_q;

  // Independent count of cycles spent on a demand fetch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      fcyc_q <= '0;
    end else begin
      fcyc_q <= (state_q == ST_FETCH) ? fcyc_q + 3'h1 : 3'h0;
    end
  end

  ws_reset_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
    !$past(rst_n) |-> ws_q == FRA_WS_RST) else $error("wait count not zero after reset");
  ws_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
    ws_q <= FRA_WS_MAX) else $error("wait count above four");
  fetch_wait_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
    (state_q == ST_FETCH && state_d != ST_FETCH) |-> fcyc_q == ws_q) else $error("fetch length wrong");
  icache_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
    take && ic_use && ic_hit |=> rd_done_q && !rd_busy_q && !rd_err_q) else $error("icache hit stalled");
  dcache_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL18
    take && dc_use && dc_hit |=> rd_done_q && rd_data_q == $past(fra_word(dc_data, rd_addr[3:2])))
    else $error("dcache hit data wrong");
  dma_bypass_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL15
    take && rd_dma |=> !fill_dc_q) else $error("dma read allocated in dcache");
  opt_nocache_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL16
    take && in_opt |=> !fill_dc_q && !fill_ic_q) else $error("option read allocated");
  cur_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
    state_q == ST_FETCH && arr_done |=> cur_val_q && cur_blk_q == $past(array_blk_q)
    && cur_buf_q == $past(array_rdata)) else $error("current buffer not loaded");
  cur_hit_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
    take && (in_main || in_opt) && !(ic_use && ic_hit) && !(dc_use && dc_hit) && cur_val_q && cur_blk_q == blk
    |=> rd_done_q && state_q == ST_IDLE) else $error("current buffer hit refetched");
  pf_instr_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
    state_q == ST_PREF |-> req_instr_q) else $error("prefetch for data read");
  pf_next_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
    state_q == ST_FETCH && arr_done && !fill_ic_q && !fill_dc_q && req_instr_q && pf_en_q
    |=> state_q == ST_PREF && array_blk_q == $past(array_blk_q) + 28'h1) else $error("no next-block prefetch");
  ic_off_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL20
    take && rd_instr && in_main && !ic_en_q && !(cur_val_q && cur_blk_q == blk)
    && !(pf_use && pf_val_q && pf_blk_q == blk)
    |=> state_q == ST_FETCH) else $error("disabled icache not bypassed");
endmodule

// File: bench/fra_flash_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Flash array model: data only on the cycle the wait count allows
// ------------------------------------------------------------
module fra_flash_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [fra_pkg::FRA_WS_W-1:0] wait_state_count,
  input wire logic array_en_q,
  input wire logic [fra_pkg::FRA_BLK_W-1:0] array_blk_q,
  output logic [fra_pkg::FRA_BLK_BITS-1:0] array_rdata
);
  import fra_pkg::*;

  logic prev_en_q, prev_en_d;
  logic [FRA_BLK_W-1:0] prev_blk_q, prev_blk_d;
  logic [3:0] age_q, age_d;
  logic [FRA_BLK_BITS-1:0] blk_data;

  // Age counts how long the current block address has stood
  always_comb begin
    prev_en_d = array_en_q;
    prev_blk_d = array_blk_q;
    if (array_en_q && prev_en_q && (array_blk_q == prev_blk_q)) begin
      age_d = (age_q == 4'hF) ? age_q : age_q + 4'h1;
    end else begin
      age_d = 4'h0;
    end
    for (int i = 0; i < 4; i++) begin
      blk_data[i*32 +: 32] = {array_blk_q, 2'(i), 2'h1};
    end
    // Outside the valid cycle show inverted data so a late or early sample is caught
    array_rdata = (array_en_q && (age_d == {1'b0, wait_state_count})) ? blk_data : ~blk_data;
  end

  // Tracking registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_en_q <= 1'b0;
      prev_blk_q <= '0;
      age_q <= 4'h0;
    end else begin
      prev_en_q <= prev_en_d;
      prev_blk_q <= prev_blk_d;
      age_q <= age_d;
    end
  end
endmodule

// File: bench/tb_flash_read_accelerator.sv
`timescale 1ns/1ps

module tb_flash_read_accelerator;
  import fra_pkg::*;

  typedef struct {
    logic [31:0] data;
    logic err;
    int cyc;
  } fra_exp_t;

  logic sys_clk, rst_n, prefetch_enable, instr_cache_enable, data_cache_enable;
  logic [FRA_WS_W-1:0] wait_state_count;
  logic rd_req, rd_instr, rd_dma, rd_busy_q, rd_done_q, rd_err_q, array_en_q;
  logic [31:0] rd_addr, rd_data_q;
  logic [FRA_BLK_W-1:0] array_blk_q;
  logic [FRA_BLK_BITS-1:0] array_rdata;
  int num_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int ws, seed;
  fra_exp_t exp_q[$];
  fra_exp_t seen_e;
  logic [31:0] a;

  fra_flash_read dut (.sys_clk(sys_clk), .rst_n(rst_n), .wait_state_count(wait_state_count),
    .prefetch_enable(prefetch_enable), .instr_cache_enable(instr_cache_enable),
    .data_cache_enable(data_cache_enable), .rd_req(rd_req), .rd_addr(rd_addr), .rd_instr(rd_instr),
    .rd_dma(rd_dma), .rd_busy_q(rd_busy_q), .rd_done_q(rd_done_q), .rd_data_q(rd_data_q),
    .rd_err_q(rd_err_q), .array_en_q(array_en_q), .array_blk_q(array_blk_q), .array_rdata(array_rdata));

  fra_flash_model flash (.sys_clk(sys_clk), .rst_n(rst_n), .wait_state_count(wait_state_count),
    .array_en_q(array_en_q), .array_blk_q(array_blk_q), .array_rdata(array_rdata));

  // ------------------------------------------------------------
  // Clock and cycle count
  // ------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) cyc <= cyc + 1;

  // ------------------------------------------------------------
  // Compare, close and watchdog
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic results();
    $display("counts: %0d comparisons, %0d mismatches", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Budget is more than fifty times the longest expected run
  initial begin
    #(50000 * 4);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end

  // Answers are checked against the oldest note, latency included
  always @(negedge sys_clk) begin
    if (rd_done_q === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(32'h1, 32'h0);
      end else begin
        seen_e = exp_q.pop_front();
        check(rd_data_q, seen_e.data);
        check({31'h0, rd_err_q}, {31'h0, seen_e.err});
        check(32'(cyc), 32'(seen_e.cyc));
      end
    end
  end

  // ------------------------------------------------------------
  // Driver tasks
  // ------------------------------------------------------------
  // Waits for the engine to idle; a stuck engine counts as a mismatch
  task automatic idle();
    int n;
    n = 0;
    @(negedge sys_clk);
    while ((rd_busy_q !== 1'b0 || exp_q.size() != 0) && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    if (n >= 200) check(32'h0, 32'h1);
  endtask

  task automatic rd(input logic [31:0] ad, input logic ins, input logic dma, input int lat);
    fra_exp_t e;
    idle();
    e.err = !((ad >= FRA_MAIN_BASE && ad <= FRA_MAIN_TOP) || (ad >= FRA_OPT_BASE && ad <= FRA_OPT_TOP));
    e.data = e.err ? 32'h0 : {ad[31:4], ad[3:2], 2'h1};
    // Answer shows in the lat-th cycle after the one the request is presented in
    e.cyc = cyc + lat;
    exp_q.push_back(e);
    rd_req = 1'b1;
    rd_addr = ad;
    rd_instr = ins;
    rd_dma = dma;
    @(negedge sys_clk);
    rd_req = 1'b0;
    rd_addr = ~ad;
  endtask

  // Settings change only while idle; the design registers them
  task automatic cfg(input int w, input logic pf, input logic ic, input logic dc);
    idle();
    ws = w;
    wait_state_count = 3'(w);
    prefetch_enable = pf;
    instr_cache_enable = ic;
    data_cache_enable = dc;
    repeat (2) @(negedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    rd_req = 1'b0;
    rd_addr = 32'h0;
    rd_instr = 1'b0;
    rd_dma = 1'b0;
    ws = 0;
    wait_state_count = 3'h0;
    prefetch_enable = 1'b0;
    instr_cache_enable = 1'b0;
    data_cache_enable = 1'b0;
    seed = $urandom(67579);
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    rd(32'h0800_0040, 1'b0, 1'b0, 2);
    $display("test reset_wait done");
    // Clock is fixed, so raising then lowering the count keeps the ordering rules
    for (int w = 0; w <= 4; w++) begin
      cfg(w, 1'b0, 1'b0, 1'b0);
      // Upper block bits follow the loop so no random block repeats the current buffer
      a = FRA_MAIN_BASE + {13'h0, 3'(w + 1), 12'($urandom_range(0, 4095)), 2'($urandom_range(0, 3)), 2'h0};
      rd(a, 1'b0, 1'b0, ws + 2);
      rd(a ^ 32'h8, 1'b0, 1'b0, 1);
      rd(a ^ 32'h6, 1'b1, 1'b0, 1);
    end
    $display("test wait_states done");
    cfg(2, 1'b0, 1'b0, 1'b0);
    rd(32'h0807_FFFC, 1'b0, 1'b0, 4);
    rd(32'h0808_0000, 1'b0, 1'b0, 1);
    rd(32'h07FF_FFFC, 1'b1, 1'b0, 1);
    $display("test address_map done");
    rd(32'h0801_0000, 1'b1, 1'b0, 4);
    rd(32'h0801_0010, 1'b1, 1'b0, 4);
    cfg(2, 1'b1, 1'b0, 1'b0);
    rd(32'h0802_0000, 1'b0, 1'b0, 4);
    rd(32'h0802_0010, 1'b0, 1'b0, 4);
    rd(32'h0803_0004, 1'b1, 1'b0, 4);
    rd(32'h0803_0018, 1'b1, 1'b0, 1);
    rd(32'h0803_0020, 1'b1, 1'b0, 1);
    $display("test prefetch done");
    cfg(1, 1'b0, 1'b1, 1'b0);
    for (int i = 0; i < 64; i++) rd(32'h0804_0000 + 32'(i * 32), 1'b1, 1'b0, 3);
    for (int i = 0; i < 64; i++) begin
      rd(32'h0804_0010 + 32'(i * 32), 1'b1, 1'b0, 1);
      rd(32'h0804_000C + 32'(i * 32), 1'b1, 1'b0, 1);
    end
    rd(32'h0804_0000, 1'b1, 1'b0, 1);
    rd(32'h0804_0800, 1'b1, 1'b0, 3);
    rd(32'h0804_0004, 1'b1, 1'b0, 1);
    rd(32'h0804_0400, 1'b1, 1'b0, 3);
    rd(32'h0804_0044, 1'b0, 1'b0, 3);
    cfg(1, 1'b0, 1'b0, 1'b0);
    rd(32'h0804_0060, 1'b1, 1'b0, 3);
    $display("test instr_cache done");
    cfg(1, 1'b0, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) rd(32'h0806_0000 + 32'(i * 32), 1'b0, 1'b0, 3);
    for (int i = 0; i < 8; i++) begin
      rd(32'h0806_0018 + 32'(i * 32), 1'b0, 1'b0, 1);
      rd(32'h0806_0004 + 32'(i * 32), 1'b0, 1'b0, 1);
    end
    rd(32'h0806_0000, 1'b0, 1'b1, 3);
    rd(32'h0806_0020, 1'b1, 1'b0, 3);
    rd(32'h1FFF_F804, 1'b0, 1'b0, 3);
    rd(32'h0806_0040, 1'b0, 1'b0, 1);
    rd(32'h0805_0000, 1'b0, 1'b1, 3);
    rd(32'h1FFF_F800, 1'b0, 1'b0, 3);
    $display("test data_cache done");
    idle();
    check(32'(exp_q.size()), 32'h0);
    check({31'h0, rd_busy_q}, 32'h0);
    check({31'h0, array_en_q}, 32'h0);
    check({4'h0, array_blk_q}, 32'h01FF_FF80);
    results();
  end
endmodule
